/* shared/tclu_pkg.sv */
// Summary of operation
// - Offset setpoint, modulation, fault and alarm thresholds
// - Four equal tables across two serial pages
// - Entries are signed bytes added as offsets
// - All entries reset to zero
// - One temperature sample per conversion period
// - Average sixteen samples, then index the tables
// - New average loads setpoint plus power offset
// - New average loads modulation and fault DACs
// - Alarm threshold compensated too, driven out on its own port
// - Above table range use the last entry
// - Below table range use the first entry
// - Each entry spans two degrees, 152 total
// - Index moves only past neighbour midpoint
// - Candidate index is average plus 46, halved, truncated
// - Entry address is index plus table base, less 64 on the extension page
// - Host can read the index in use
// - Entries 0-63 main page, 64-75 extension
// - Entry 0 at -45 or below, 75 at 104 up
// - Diode fault forces samples to +127
package tclu_pkg;
  localparam int CLK_PERIOD_NS        = 25;
  localparam int CONVERSION_PERIOD_NS = 100_000_000;
  localparam int CONV_CYCLES          = CONVERSION_PERIOD_NS / CLK_PERIOD_NS;
  localparam int CONV_CNT_W           = 22;
  localparam int AVG_SAMPLES          = 16;
  localparam int AVG_SHIFT            = 4;
  localparam int SUM_W                = 12;
  localparam int TEMP_W               = 8;
  localparam logic signed [TEMP_W-1:0] DIODE_FAULT_TEMP = 8'sh7F;
  localparam int NUM_TABLES           = 4;
  localparam int TABLE_ENTRIES        = 76;
  localparam int IDX_W                = 7;
  localparam logic [IDX_W-1:0] PRIMARY_ENTRIES = 7'h40;
  localparam logic [7:0] EXT_ENTRIES  = 8'h0C;
  localparam logic [IDX_W-1:0] LAST_INDEX = 7'h4B;
  // Offset added to temperature so -46 maps to half-index 0 of entry 0
  localparam logic signed [9:0] TEMP_INDEX_BIAS = 10'sh02E;
  localparam logic signed [9:0] HYST_UP = 10'sh003;
  localparam logic signed [9:0] HYST_DN = 10'sh002;
  localparam logic [7:0] APC_OFFSET_TABLE            = 8'h00;
  localparam logic [7:0] MODULATION_OFFSET_TABLE     = 8'h40;
  localparam logic [7:0] BIAS_FAULT_OFFSET_TABLE     = 8'h80;
  localparam logic [7:0] BIAS_ALARM_OFFSET_TABLE     = 8'hC0;
  localparam logic [7:0] APC_OFFSET_TABLE_EXT        = 8'h90;
  localparam logic [7:0] MODULATION_OFFSET_TABLE_EXT = 8'hA0;
  localparam logic [7:0] BIAS_FAULT_OFFSET_TABLE_EXT = 8'hB0;
  localparam logic [7:0] BIAS_ALARM_OFFSET_TABLE_EXT = 8'hC0;
  localparam logic [NUM_TABLES-1:0][7:0] PRI_BASE = {
    BIAS_ALARM_OFFSET_TABLE, BIAS_FAULT_OFFSET_TABLE,
    MODULATION_OFFSET_TABLE, APC_OFFSET_TABLE};
  localparam logic [NUM_TABLES-1:0][7:0] EXT_BASE = {
    BIAS_ALARM_OFFSET_TABLE_EXT, BIAS_FAULT_OFFSET_TABLE_EXT,
    MODULATION_OFFSET_TABLE_EXT, APC_OFFSET_TABLE_EXT};
  localparam logic [7:0] PAGE_MAIN_DELTA = 8'h04;
  localparam logic [7:0] PAGE_EXT_DELTA  = 8'h06;
  localparam logic [7:0] INDEX_STATUS_ADDR = 8'hF0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [7:0] DAC_MAX = 8'hFF;
endpackage : tclu_pkg

/* shared/tclu_lut_if.sv */
`timescale 1ns/10ps
interface tclu_lut_if;
  logic                                      host_we;
  logic                                      host_page;
  logic [7:0]                                host_addr;
  logic [7:0]                                host_wdata;
  logic [7:0]                                host_rdata;
  logic [tclu_pkg::IDX_W-1:0]                eng_index;
  logic [tclu_pkg::NUM_TABLES-1:0][7:0]      eng_offset;
  modport mem (
    input  host_we, host_page, host_addr, host_wdata, eng_index,
    output host_rdata, eng_offset
  );
  modport eng (
    output host_we, host_page, host_addr, host_wdata, eng_index,
    input  host_rdata, eng_offset
  );
endinterface : tclu_lut_if

/* logic/tclu_averager.sv */
`timescale 1ns/10ps
module tclu_averager (
  input  wire logic                                clk,
  input  wire logic                                rst_b,
  input  wire logic                                sample_en,
  input  wire logic signed [tclu_pkg::TEMP_W-1:0]  temp_in,
  input  wire logic                                diode_fault,
  output logic signed [tclu_pkg::TEMP_W-1:0]       avg_out,
  output logic                                     avg_valid
);
  logic signed [tclu_pkg::SUM_W-1:0]  sum_q, sum_d, sum_full;
  logic [3:0]                         cnt_q, cnt_d;
  logic signed [tclu_pkg::TEMP_W-1:0] avg_q, avg_d, sample;
  logic                               vld_q, vld_d;

  always_comb begin
    sample   = diode_fault ? tclu_pkg::DIODE_FAULT_TEMP : temp_in;
    sum_full = sum_q + tclu_pkg::SUM_W'(sample);
    sum_d    = sum_q;
    cnt_d    = cnt_q;
    avg_d    = avg_q;
    vld_d    = 1'b0;
    if (sample_en) begin
      cnt_d = cnt_q + 4'h1;
      if (cnt_q == 4'(tclu_pkg::AVG_SAMPLES - 1)) begin
        // Floor division keeps negative averages stable
        avg_d = tclu_pkg::TEMP_W'(sum_full >>> tclu_pkg::AVG_SHIFT);
        vld_d = 1'b1;
        sum_d = '0;
      end else begin
        sum_d = sum_full;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sum_q <= '0;
      cnt_q <= '0;
      avg_q <= '0;
      vld_q <= 1'b0;
    end else begin
      sum_q <= sum_d;
      cnt_q <= cnt_d;
      avg_q <= avg_d;
      vld_q <= vld_d;
    end
  end

  assign avg_out   = avg_q;
  assign avg_valid = vld_q;
endmodule : tclu_averager

/* logic/tclu_lut_mem.sv */
`timescale 1ns/10ps
module tclu_lut_mem (
  input  wire logic  clk,
  input  wire logic  rst_b,
  tclu_lut_if.mem    lut
);
  localparam int NT = tclu_pkg::NUM_TABLES;
  localparam int NE = tclu_pkg::TABLE_ENTRIES;

  logic [7:0] lut_q [NT][NE];
  logic [7:0] lut_d [NT][NE];
  logic [NT-1:0]        hit;
  logic [NT-1:0][7:0]   rel;
  logic [NT-1:0][6:0]   entry;

  genvar t;
  generate
    for (t = 0; t < NT; t++) begin : g_tbl
      always_comb begin
        if (!lut.host_page) begin
          rel[t] = lut.host_addr - tclu_pkg::PRI_BASE[t];
          hit[t] = rel[t] < 8'(tclu_pkg::PRIMARY_ENTRIES);
          entry[t] = rel[t][6:0];
        end else begin
          rel[t] = lut.host_addr - tclu_pkg::EXT_BASE[t];
          hit[t] = rel[t] < tclu_pkg::EXT_ENTRIES;
          entry[t] = rel[t][6:0] + tclu_pkg::PRIMARY_ENTRIES;
        end
      end
      assign lut.eng_offset[t] = lut_q[t][lut.eng_index];
    end
  endgenerate

  always_comb begin
    lut_d = lut_q;
    lut.host_rdata = 8'h00;
    for (int i = 0; i < NT; i++) begin
      if (hit[i]) begin
        lut.host_rdata = lut_q[i][entry[i]];
        if (lut.host_we) begin
          lut_d[i][entry[i]] = lut.host_wdata;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NT; i++) begin
        for (int j = 0; j < NE; j++) begin
          lut_q[i][j] <= 8'h00;
        end
      end
    end else begin
      lut_q <= lut_d;
    end
  end
endmodule : tclu_lut_mem

/* logic/tclu_engine.sv */
`timescale 1ns/10ps
module tclu_engine #(
  parameter int CONV_CYCLES = tclu_pkg::CONV_CYCLES
) (
  input  wire logic                                clk,
  input  wire logic                                rst_b,
  input  wire logic                                scl_i,
  input  wire logic                                sda_i,
  output logic                                     sda_o,
  output logic                                     sda_oe,
  input  wire logic [7:0]                          serial_base_device_address,
  input  wire logic signed [tclu_pkg::TEMP_W-1:0]  adc_temperature,
  input  wire logic                                sense_diode_fault_flag,
  input  wire logic [7:0]                          nominal_power_setpoint,
  input  wire logic [7:0]                          nominal_modulation_current,
  input  wire logic [7:0]                          nominal_bias_fault_threshold,
  input  wire logic [7:0]                          nominal_bias_alarm_threshold,
  output logic [7:0]                               power_setpoint_out,
  output logic [7:0]                               modulation_current_out,
  output logic [7:0]                               bias_fault_threshold_out,
  output logic [7:0]                               bias_alarm_threshold_out,
  output logic                                     comp_update,
  output logic                                     conv_strobe,
  output logic [tclu_pkg::IDX_W-1:0]               current_table_index,
  output logic signed [tclu_pkg::TEMP_W-1:0]       averaged_temperature
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_DEV, ST_DEV_ACK, ST_PTR, ST_PTR_ACK,
    ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
  } tclu_i2c_state_e;

  tclu_lut_if lut ();

  // Conversion cadence
  logic [tclu_pkg::CONV_CNT_W-1:0] conv_cnt_q, conv_cnt_d;
  logic                            conv_tick;

  always_comb begin
    conv_tick  = conv_cnt_q == tclu_pkg::CONV_CNT_W'(CONV_CYCLES - 1);
    conv_cnt_d = conv_tick ? '0 : conv_cnt_q + 1'b1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_cnt_q <= '0;
    end else begin
      conv_cnt_q <= conv_cnt_d;
    end
  end

  assign conv_strobe = conv_tick;

  logic signed [tclu_pkg::TEMP_W-1:0] current_mean_temperature;
  logic                               avg_valid;

  tclu_averager u_avg (
    .clk         (clk),
    .rst_b       (rst_b),
    .sample_en   (conv_tick),
    .temp_in     (adc_temperature),
    .diode_fault (sense_diode_fault_flag),
    .avg_out     (current_mean_temperature),
    .avg_valid   (avg_valid)
  );

  tclu_lut_mem u_mem (
    .clk   (clk),
    .rst_b (rst_b),
    .lut   (lut.mem)
  );

  // Index selection with hysteresis
  logic [tclu_pkg::IDX_W-1:0] idx_q, idx_d, cand;
  logic signed [9:0]          half_pos, cur2;
  logic                       apply_q, apply_d;

  always_comb begin
    half_pos = 10'(current_mean_temperature) + tclu_pkg::TEMP_INDEX_BIAS;
    cur2     = 10'({idx_q, 1'b0});
    if (half_pos < 10'sh000) begin
      cand = '0;
    end else if ((half_pos >>> 1) > 10'(tclu_pkg::LAST_INDEX)) begin
      cand = tclu_pkg::LAST_INDEX;
    end else begin
      cand = tclu_pkg::IDX_W'(half_pos >>> 1);
    end
    idx_d   = idx_q;
    apply_d = avg_valid;
    if (avg_valid) begin
      // Two-degree bands, move only past the neighbour's midpoint
      if (half_pos >= cur2 + tclu_pkg::HYST_UP ||
          half_pos <= cur2 - tclu_pkg::HYST_DN) begin
        idx_d = cand;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      idx_q   <= '0;
      apply_q <= 1'b0;
    end else begin
      idx_q   <= idx_d;
      apply_q <= apply_d;
    end
  end

  assign lut.eng_index        = idx_q;
  assign current_table_index  = idx_q;
  assign averaged_temperature = current_mean_temperature;

  // Compensated outputs
  logic [3:0][7:0] nominal;
  logic [3:0][7:0] comp_q, comp_d;
  logic            upd_q, upd_d;

  function automatic logic [7:0] sat_add(input logic [7:0] nom,
                                         input logic [7:0] off);
    logic signed [9:0] sum;
    sum = $signed({2'b00, nom}) + $signed({{2{off[7]}}, off});
    if (sum < 10'sh000) begin
      sat_add = 8'h00;
    end else if (sum > $signed({2'b00, tclu_pkg::DAC_MAX})) begin
      sat_add = tclu_pkg::DAC_MAX;
    end else begin
      sat_add = sum[7:0];
    end
  endfunction : sat_add

  assign nominal = {nominal_bias_alarm_threshold, nominal_bias_fault_threshold,
                    nominal_modulation_current, nominal_power_setpoint};

  always_comb begin
    comp_d = comp_q;
    upd_d  = apply_q;
    if (apply_q) begin
      for (int i = 0; i < tclu_pkg::NUM_TABLES; i++) begin
        comp_d[i] = sat_add(nominal[i], lut.eng_offset[i]);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      comp_q <= '0;
      upd_q  <= 1'b0;
    end else begin
      comp_q <= comp_d;
      upd_q  <= upd_d;
    end
  end

  assign power_setpoint_out       = comp_q[0];
  assign modulation_current_out   = comp_q[1];
  assign bias_fault_threshold_out = comp_q[2];
  // Compensated alarm threshold drives the bias_alarm_threshold_out port
  assign bias_alarm_threshold_out = comp_q[3];
  assign comp_update              = upd_q;

  // Pin conditioning: three stages, accept when stages two and three agree
  logic [2:0] scl_s_q, sda_s_q;
  logic       scl_f_q, sda_f_q, scl_p_q, sda_p_q;
  logic       scl_f_d, sda_f_d;

  always_comb begin
    scl_f_d = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_f_q;
    sda_f_d = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_f_q;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[1:0], scl_i};
      sda_s_q <= {sda_s_q[1:0], sda_i};
      scl_f_q <= scl_f_d;
      sda_f_q <= sda_f_d;
      scl_p_q <= scl_f_q;
      sda_p_q <= sda_f_q;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise  = scl_f_q & ~scl_p_q;
  assign scl_fall  = ~scl_f_q & scl_p_q;
  assign bus_start = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
  assign bus_stop  = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;

  // Serial slave for the two table pages
  tclu_i2c_state_e st_q, st_d;
  logic [7:0] shift_q, shift_d, ptr_q, ptr_d, rdata;
  logic [7:0] dev_main, dev_ext;
  logic [3:0] cnt_q, cnt_d;
  logic       page_q, page_d, rw_q, rw_d, drive_q, drive_d, we;

  always_comb begin
    dev_main = serial_base_device_address + tclu_pkg::PAGE_MAIN_DELTA;
    dev_ext  = serial_base_device_address + tclu_pkg::PAGE_EXT_DELTA;
    if (page_q && ptr_q == tclu_pkg::INDEX_STATUS_ADDR) begin
      rdata = {1'b0, idx_q};
    end else begin
      rdata = lut.host_rdata;
    end
  end

  always_comb begin
    st_d    = st_q;
    shift_d = shift_q;
    ptr_d   = ptr_q;
    cnt_d   = cnt_q;
    page_d  = page_q;
    rw_d    = rw_q;
    drive_d = drive_q;
    we      = 1'b0;
    if (bus_start) begin
      st_d    = ST_DEV;
      cnt_d   = '0;
      drive_d = 1'b0;
    end else if (bus_stop) begin
      st_d    = ST_IDLE;
      drive_d = 1'b0;
    end else begin
      case (st_q)
        ST_DEV, ST_PTR, ST_WR: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda_f_q};
            cnt_d   = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == tclu_pkg::BITS_PER_BYTE) begin
            cnt_d   = '0;
            drive_d = 1'b1;
            if (st_q == ST_DEV) begin
              if (shift_q[7:1] == dev_main[7:1]) begin
                page_d = 1'b0;
                rw_d   = shift_q[0];
                st_d   = ST_DEV_ACK;
              end else if (shift_q[7:1] == dev_ext[7:1]) begin
                page_d = 1'b1;
                rw_d   = shift_q[0];
                st_d   = ST_DEV_ACK;
              end else begin
                // Not our address: stay silent until next start
                drive_d = 1'b0;
                st_d    = ST_IDLE;
              end
            end else if (st_q == ST_PTR) begin
              ptr_d = shift_q;
              st_d  = ST_PTR_ACK;
            end else begin
              we   = 1'b1;
              st_d = ST_WR_ACK;
            end
          end
        end
        ST_DEV_ACK: begin
          if (scl_fall) begin
            if (rw_q) begin
              shift_d = rdata;
              drive_d = ~rdata[7];
              st_d    = ST_RD;
            end else begin
              drive_d = 1'b0;
              st_d    = ST_PTR;
            end
          end
        end
        ST_PTR_ACK, ST_WR_ACK: begin
          if (scl_fall) begin
            drive_d = 1'b0;
            st_d    = ST_WR;
            if (st_q == ST_WR_ACK) begin
              ptr_d = ptr_q + 8'h01;
            end
          end
        end
        ST_RD: begin
          if (scl_rise) begin
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (cnt_q == tclu_pkg::BITS_PER_BYTE) begin
              cnt_d   = '0;
              drive_d = 1'b0;
              ptr_d   = ptr_q + 8'h01;
              st_d    = ST_RD_ACK;
            end else begin
              drive_d = ~shift_q[6];
              shift_d = {shift_q[6:0], 1'b0};
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise && sda_f_q) begin
            st_d = ST_IDLE;
          end else if (scl_fall) begin
            shift_d = rdata;
            drive_d = ~rdata[7];
            st_d    = ST_RD;
          end
        end
        default: begin
          drive_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q    <= ST_IDLE;
      shift_q <= 8'h00;
      ptr_q   <= 8'h00;
      cnt_q   <= 4'h0;
      page_q  <= 1'b0;
      rw_q    <= 1'b0;
      drive_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      shift_q <= shift_d;
      ptr_q   <= ptr_d;
      cnt_q   <= cnt_d;
      page_q  <= page_d;
      rw_q    <= rw_d;
      drive_q <= drive_d;
    end
  end

  // Host writes land in the tables; the index status byte is read only
  assign lut.host_we    = we;
  assign lut.host_page  = page_q;
  assign lut.host_addr  = ptr_q;
  assign lut.host_wdata = shift_q;

  // Open drain: only ever pulls low
  assign sda_o  = 1'b0;
  assign sda_oe = drive_q;
endmodule : tclu_engine

/* test/tclu_engine_monitor.sv */
`timescale 1ns/10ps
module tclu_engine_monitor #(
  parameter int CONV_CYCLES = 16
) (
  input wire logic                              clk,
  input wire logic                              rst_b,
  input wire logic                              conv_strobe,
  input wire logic                              comp_update,
  input wire logic                              sense_diode_fault_flag,
  input wire logic [tclu_pkg::IDX_W-1:0]        current_table_index,
  input wire logic signed [tclu_pkg::TEMP_W-1:0] averaged_temperature,
  input wire logic [7:0]                        power_setpoint_out,
  input wire logic [7:0]                        modulation_current_out,
  input wire logic [7:0]                        bias_fault_threshold_out,
  input wire logic [7:0]                        bias_alarm_threshold_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [3:0]        nstrb_q, nstrb_d;
  logic [31:0]       gap_q, gap_d;
  logic              seen_q, seen_d, flt_q, flt_d, grp_end;
  logic [6:0]        idx_q, cand;
  logic signed [9:0] t46, two_old;
  logic [7:0]        half_t;
  // Group count assumes the first strobe after reset opens a group
  always_comb begin
    grp_end = conv_strobe && nstrb_q == 4'hF;
    nstrb_d = nstrb_q + {3'h0, conv_strobe};
    gap_d   = conv_strobe ? 32'h0 : gap_q + 32'h1;
    seen_d  = seen_q || conv_strobe;
    flt_d   = flt_q;
    if (conv_strobe) begin
      flt_d = (flt_q || nstrb_q == 4'h0) && sense_diode_fault_flag;
    end
    t46     = 10'(averaged_temperature) + 10'sh02E;
    half_t  = t46[8:1];
    cand    = t46 < 0 ? 7'h00 : half_t > 8'h4B ? 7'h4B : half_t[6:0];
    two_old = {2'b00, idx_q, 1'b0};
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      nstrb_q <= 4'h0;
      gap_q   <= 32'h0;
      seen_q  <= 1'b0;
      flt_q   <= 1'b0;
      idx_q   <= 7'h00;
    end else begin
      nstrb_q <= nstrb_d;
      gap_q   <= gap_d;
      seen_q  <= seen_d;
      flt_q   <= flt_d;
      idx_q   <= current_table_index;
    end
  end
  sequence walk_s;
    !comp_update ##1 !comp_update ##1 comp_update;
  endsequence
  strobe_period_a: assert property (
    seen_q && (conv_strobe || gap_q >= CONV_CYCLES - 1)
    |-> conv_strobe && gap_q == CONV_CYCLES - 1) else $error("strobe gap");
  update_walk_a: assert property (
    grp_end |=> walk_s) else $error("update late after group");
  update_cause_a: assert property (
    comp_update |-> $past(grp_end, 3)) else $error("update without group");
  avg_change_a: assert property (
    $changed(averaged_temperature) |-> $past(grp_end))
    else $error("average moved mid group");
  index_range_a: assert property (
    current_table_index <= 7'h4B) else $error("index out of range");
  index_change_a: assert property (
    $changed(current_table_index) |-> $past(grp_end, 2))
    else $error("index moved off schedule");
  index_rule_a: assert property (
    $past(grp_end, 2) |-> current_table_index ==
    ((t46 >= two_old + 3 || t46 <= two_old - 2) ? cand : idx_q))
    else $error("index value wrong");
  out_hold_a: assert property (
    !comp_update |-> $stable(power_setpoint_out)
    && $stable(modulation_current_out) && $stable(bias_fault_threshold_out)
    && $stable(bias_alarm_threshold_out)) else $error("output moved");
  fault_avg_a: assert property (
    grp_end && flt_d |=> averaged_temperature == 8'sh7F)
    else $error("fault average wrong");
endmodule : tclu_engine_monitor
bind tclu_engine tclu_engine_monitor #(.CONV_CYCLES(CONV_CYCLES)) u_mon (
  .clk, .rst_b, .conv_strobe, .comp_update, .sense_diode_fault_flag,
  .current_table_index, .averaged_temperature, .power_setpoint_out,
  .modulation_current_out, .bias_fault_threshold_out,
  .bias_alarm_threshold_out);

/* test/tclu_host_model.sv */
`timescale 1ns/10ps
module tclu_host_model (
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_pull
);
  // Idle bus: clock high, data released to the pull-up
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic pause(input int n);
    repeat (n) @(negedge clk);
  endtask : pause
  // Ten-clock phases stay clear of the three-flop input filter
  task automatic start_cond();
    pause(2);
    sda_pull = 1'b0;
    pause(8);
    scl = 1'b1;
    pause(10);
    sda_pull = 1'b1;
    pause(10);
    scl = 1'b0;
  endtask : start_cond
  task automatic stop_cond();
    pause(2);
    sda_pull = 1'b1;
    pause(8);
    scl = 1'b1;
    pause(10);
    sda_pull = 1'b0;
    pause(10);
  endtask : stop_cond
  // Data moves only while the clock is low, sampled at the rise
  task automatic bit_slot(input logic b, output logic r);
    pause(2);
    sda_pull = !b;
    pause(8);
    scl = 1'b1;
    r = sda_line;
    pause(10);
    scl = 1'b0;
  endtask : bit_slot
  task automatic xfer(input logic [7:0] w, input logic ack_in,
                      output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_slot(w[i], r[i]);
    end
    bit_slot(ack_in, ack);
  endtask : xfer
endmodule : tclu_host_model

/* test/tclu_engine_test.sv */
`timescale 1ns/10ps
module tclu_engine_test;
  localparam int CONV = 16;
  localparam logic [7:0] MAIN = 8'hA4;
  localparam logic [7:0] EXT = 8'hA6;
  localparam logic [3:0][7:0] PB = {8'hC0, 8'h80, 8'h40, 8'h00};
  localparam logic [3:0][7:0] EB = {8'hC0, 8'hB0, 8'hA0, 8'h90};
  logic              clk, rst_b, scl, host_pull, sda_o, sda_oe, flag;
  logic              upd, strb;
  logic [6:0]        idx;
  logic signed [7:0] adc, avg;
  logic [3:0][7:0]   nom;
  wire  [3:0][7:0]   outs;
  wire               sda_line;
  logic signed [7:0] tbl [4][76] = '{default: 8'sh00};
  int                n_errors, n_checks, exp_idx, b_prev;
  assign sda_line = !(host_pull || sda_oe);
  tclu_engine #(.CONV_CYCLES(CONV)) uut (
    .clk, .rst_b, .scl_i(scl), .sda_i(sda_line), .sda_o, .sda_oe,
    .serial_base_device_address(8'hA0), .adc_temperature(adc),
    .sense_diode_fault_flag(flag), .nominal_power_setpoint(nom[0]),
    .nominal_modulation_current(nom[1]),
    .nominal_bias_fault_threshold(nom[2]),
    .nominal_bias_alarm_threshold(nom[3]), .power_setpoint_out(outs[0]),
    .modulation_current_out(outs[1]), .bias_fault_threshold_out(outs[2]),
    .bias_alarm_threshold_out(outs[3]), .comp_update(upd),
    .conv_strobe(strb), .current_table_index(idx),
    .averaged_temperature(avg));
  tclu_host_model host (.clk, .sda_line, .scl, .sda_pull(host_pull));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic report_and_stop();
    if (n_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] sat(input logic [7:0] n,
                                     input logic signed [7:0] o);
    int v;
    v = int'(n) + int'(o);
    return v < 0 ? 8'h00 : v > 255 ? 8'hFF : 8'(v);
  endfunction : sat
  // Next index from the band rule, clamped to the table
  function automatic int nidx(input int i, input int a);
    int t;
    int c;
    t = a + 46;
    c = t < 0 ? 0 : t / 2 > 75 ? 75 : t / 2;
    return (t >= 2 * i + 3 || t <= 2 * i - 2) ? c : i;
  endfunction : nidx
  task automatic acked(input logic [7:0] b);
    logic [7:0] r;
    logic a;
    host.xfer(b, 1'b1, r, a);
    chk({7'h0, a}, 8'h00);
  endtask : acked
  task automatic wr(input logic [7:0] pg, ptr, dat);
    host.start_cond();
    acked(pg);
    acked(ptr);
    acked(dat);
    host.stop_cond();
  endtask : wr
  task automatic rd(input logic [7:0] pg, ptr, exp);
    logic [7:0] r;
    logic a;
    host.start_cond();
    acked(pg);
    acked(ptr);
    host.start_cond();
    acked(pg | 8'h01);
    host.xfer(8'hFF, 1'b1, r, a);
    host.stop_cond();
    chk(r, exp);
  endtask : rd
  task automatic wr_entry(input int t, input int i, input logic [7:0] v);
    if (i < 64) wr(MAIN, 8'(PB[t] + i), v);
    else wr(EXT, 8'(EB[t] + i - 64), v);
    tbl[t][i] = v;
  endtask : wr_entry
  task automatic wait_upd();
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (upd !== 1'b1 && k < 400);
    chk({7'h0, upd}, 8'h01);
  endtask : wait_upd
  // Samples held between groups repeat the last value, so one step covers
  task automatic group(input int a, input int b, input logic f);
    int ea;
    int k;
    exp_idx = nidx(exp_idx, b_prev);
    wait_upd();
    for (int i = 0; i < 16; i++) begin
      k = 0;
      do begin
        @(negedge clk);
        k++;
      end while (strb !== 1'b1 && k < 40);
      chk({7'h0, strb}, 8'h01);
      adc = 8'(i < 15 ? a : b);
      flag = f;
    end
    wait_upd();
    flag = 1'b0;
    ea = f ? 127 : (15 * a + b) >>> 4;
    exp_idx = nidx(exp_idx, ea);
    b_prev = b;
    chk(avg, 8'(ea));
    chk({1'b0, idx}, 8'(exp_idx));
    for (int t = 0; t < 4; t++) chk(outs[t], sat(nom[t], tbl[t][exp_idx]));
  endtask : group
  task automatic t_reset();
    for (int t = 0; t < 4; t++) chk(outs[t], 8'h00);
    chk({1'b0, idx}, 8'h00);
    rd(MAIN, 8'h00, 8'h00);
    rd(EXT, 8'hCB, 8'h00);
    rd(EXT, 8'hF0, 8'h17);
  endtask : t_reset
  task automatic t_regs();
    logic [7:0] r;
    logic a;
    wr_entry(1, 5, 8'h7F);
    rd(MAIN, 8'h45, 8'h7F);
    wr_entry(3, 70, 8'h9C);
    rd(EXT, 8'hC6, 8'h9C);
    wr(EXT, 8'hF0, 8'h33);
    rd(EXT, 8'hF0, 8'h17);
    rd(EXT, 8'h10, 8'h00);
    host.start_cond();
    acked(MAIN);
    acked(8'h46);
    acked(8'h11);
    acked(8'h22);
    host.start_cond();
    acked(MAIN);
    acked(8'h46);
    host.start_cond();
    acked(8'hA5);
    host.xfer(8'hFF, 1'b0, r, a);
    chk(r, 8'h11);
    host.xfer(8'hFF, 1'b1, r, a);
    chk(r, 8'h22);
    host.start_cond();
    host.xfer(8'hB4, 1'b1, r, a);
    host.stop_cond();
    chk({7'h0, a}, 8'h01);
  endtask : t_regs
  task automatic t_comp();
    group(20, 20, 1'b0);
    wr_entry(0, 33, 8'h05);
    wr_entry(1, 33, 8'hFD);
    wr_entry(2, 33, 8'h7F);
    wr_entry(3, 33, 8'h80);
    group(21, 21, 1'b0);
  endtask : t_comp
  task automatic t_hyst();
    group(22, 23, 1'b0);
    group(23, 23, 1'b0);
    group(18, 17, 1'b0);
    group(-3, -4, 1'b0);
  endtask : t_hyst
  task automatic t_clamp();
    wr_entry(0, 75, 8'h05);
    wr_entry(3, 75, 8'h01);
    wr_entry(0, 0, 8'hF6);
    group(110, 110, 1'b0);
    group(-60, -60, 1'b0);
    group(20, 127, 1'b1);
    rd(EXT, 8'hF0, 8'h4B);
  endtask : t_clamp
  initial begin
    rst_b = 1'b0;
    adc = 8'sh00;
    flag = 1'b0;
    nom = {8'h40, 8'hF0, 8'h10, 8'h80};
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_regs();
    t_comp();
    t_hyst();
    t_clamp();
    report_and_stop();
  end
  // Whole sequence needs about 19000 cycles
  initial begin
    repeat (80000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
endmodule : tclu_engine_test
